// ---- rtl/iscr_lane_shifter.sv ----
/*
 * Link-domain readout shifter: sends one result word over one, two or
 * four lanes, launching each chunk on a rising serial clock edge.
 * Assumes word_i and lanes_i are held stable by the local domain for
 * the whole frame; frame_b_i high clears everything asynchronously,
 * since the serial clock stops between frames.
 */
module iscr_lane_shifter (
    input  wire logic                   link_sclk_i,
    input  wire logic                   frame_b_i,
    input  wire logic [19:0]            word_i,
    input  wire iscr_pkg::iscr_lanes_type lanes_i,
    output logic      [3:0]             lanes_o,
    output logic                        done_o
);
    import iscr_pkg::*;

    logic [19:0] shreg;
    logic [4:0]  count;
    logic [19:0] src;
    logic [19:0] next_shreg;
    logic [3:0]  next_lanes;
    logic [2:0]  width;
    logic [4:0]  clocks;
    logic        at_end;

    // lane width and word length per mode
    assign width  = (lanes_i == ISCR_LANES_FOUR) ? WIDTH_FOUR_LANE :
                    (lanes_i == ISCR_LANES_TWO)  ? WIDTH_TWO_LANE  : WIDTH_ONE_LANE; // R1
    assign clocks = (lanes_i == ISCR_LANES_FOUR) ? CLOCKS_FOUR_LANE :
                    (lanes_i == ISCR_LANES_TWO)  ? CLOCKS_TWO_LANE  : CLOCKS_ONE_LANE; // R10
    assign at_end = (count == clocks);

    // first edge of the frame takes the word straight from the hold register
    assign src        = (count == RST_COUNT) ? word_i : shreg;
    assign next_shreg = src << width;

    // lane i carries bit (20 - width + i); highest used lane carries the msb
    genvar i;
    generate
        for (i = 0; i < LANES; i++) begin : g_lane
            logic       used;
            logic [4:0] idx;
            assign used          = (3'(i) < width);
            assign idx           = used ? 5'(RESULT_BITS - int'(width) + i) : 5'h00;
            assign next_lanes[i] = used & src[idx]; // R1
        end
    endgenerate

    // shift until the word is out, then park the lanes low; done is a
    // flop because it crosses to the local clock, where a glitch from
    // the count compare could be caught as a false completion
    always_ff @(posedge link_sclk_i or posedge frame_b_i) begin
        if (frame_b_i) begin
            shreg   <= RST_WORD;
            count   <= RST_COUNT;
            lanes_o <= RST_LANES;
            done_o  <= 1'b0;
        end else if (!at_end) begin
            shreg   <= next_shreg;
            count   <= count + 5'h01; // R10
            lanes_o <= next_lanes;
            done_o  <= (count == clocks - 5'h01); // R10
        end else begin
            lanes_o <= RST_LANES;
        end
    end

endmodule

// ---- rtl/iscr_pkg.sv ----
/*
 * Shared constants and types for the isolated sample clock retimer:
 * result width, lane widths, clocks per readout word, reset values.
 * Assumes a 200 MHz local low-jitter clock and a host serial clock
 * that only toggles while a readout frame is open.
 */
// Function
// [R1] Readout drives one, two or four data-out lanes, chosen by the host.
// [R2] Readout offers converter-clocked mode or source-synchronous mode besides lane width.
// [R3] In source-synchronous mode the host serial clock is looped back beside the data.
// [R4] Source-synchronous mode drives a returned strobe clock aligned with data-out lanes.
// [R5] Host picks source-synchronous mode when loopback delay limits its serial clock.
// [R6] Low-jitter clock is made locally and sent out as the host side clock.
// [R7] Host derives sample start from its received clock and sends it back.
// [R8] Isolated sample start passes a flip-flop on the local clock before the converter.
// [R9] Host captures source-synchronous data with a receiver clocked by the returned strobe.
// [R10] One 20-bit word takes 20, 10 or 5 serial clocks for 1, 2, 4 lanes.
// [R11] Sample start is retimed on the rising edge of the local low-jitter clock.
package iscr_pkg;

    localparam int          RESULT_BITS      = 20;
    localparam int          LANES            = 4;

    // serial clocks per word, by lane width
    localparam logic [4:0]  CLOCKS_ONE_LANE  = 5'h14;
    localparam logic [4:0]  CLOCKS_TWO_LANE  = 5'h0a;
    localparam logic [4:0]  CLOCKS_FOUR_LANE = 5'h05;

    // lanes driven per serial clock
    localparam logic [2:0]  WIDTH_ONE_LANE   = 3'h1;
    localparam logic [2:0]  WIDTH_TWO_LANE   = 3'h2;
    localparam logic [2:0]  WIDTH_FOUR_LANE  = 3'h4;

    // host side clock toggles after this many local cycles
    localparam logic [3:0]  HOST_CLK_HALF    = 4'h1;

    // reset values
    localparam logic [19:0] RST_WORD         = 20'h0_0000;
    localparam logic [3:0]  RST_LANES        = 4'h0;
    localparam logic [4:0]  RST_COUNT        = 5'h00;
    localparam logic [3:0]  RST_DIV          = 4'h0;

    typedef enum logic [1:0] {
        ISCR_LANES_ONE,
        ISCR_LANES_TWO,
        ISCR_LANES_FOUR
    } iscr_lanes_type;

    typedef enum logic {
        ISCR_MODE_CONV_CLOCKED,
        ISCR_MODE_SOURCE_SYNC
    } iscr_mode_type;

endpackage

// ---- rtl/iscr_retimer.sv ----
/*
 * Converter-side digital logic of an isolated acquisition link:
 * makes the host side clock from the local low-jitter clock, retimes
 * the isolated sample start onto that clock, holds each conversion
 * result and sends it to the host over the multi-lane serial readout,
 * optionally with a returned strobe clock.
 * Assumes the converter core delivers results on clk_i, and the host
 * drives frame_b_i and link_sclk_i as an ordinary serial master that
 * waits a few local cycles between frame start and the first clock.
 * The link logic has no reset of its own: a rising frame_b_i clears
 * it, so the host raises frame_b_i once before its first frame. Mode
 * straps may only move while the link is idle.
 */
module iscr_retimer (
    input  wire logic        clk_i,
    input  wire logic        rst_b_i,
    // sample start path
    input  wire logic        isolated_sample_start_i,
    output logic             host_side_clock_o,
    output logic             retimed_sample_start_o,
    output logic             sample_start_edge_o,
    // converter core result
    input  wire logic [19:0] conv_result_i,
    input  wire logic        conv_result_valid_i,
    // mode straps from the host
    input  wire logic [1:0]  lane_sel_i,
    input  wire logic        source_sync_sel_i,
    // serial readout link
    input  wire logic        link_sclk_i,
    input  wire logic        frame_b_i,
    output logic      [3:0]  serial_data_out_lanes_o,
    output logic             returned_strobe_clock_o,
    // status
    output logic             word_ready_o,
    output logic             overrun_o,
    output logic             short_frame_o
);
    import iscr_pkg::*;

    // host side clock divider
    logic [3:0]  div_count;
    logic        next_div_wrap;

    // sample start retiming
    logic        start_retime;
    logic        start_q;
    logic        start_qq;

    // mode straps
    logic [2:0]  strap_sync;
    logic [2:0]  strap_zero;
    logic [1:0]  lane_sel_sync;
    logic        source_sync_sync;
    iscr_lanes_type lanes_req;
    iscr_lanes_type lanes_held;
    iscr_mode_type  mode_req;
    iscr_mode_type  mode_held;

    // frame tracking
    logic        frame_b_sync;
    logic        frame_b_prev;
    logic        frame_open;
    logic        frame_start;
    logic        frame_end;
    logic        done_sync;

    // result hold
    logic [19:0] hold_word;
    logic        take_result;
    logic        drop_result;

    // link domain
    logic [3:0]  link_lanes;
    logic        link_done;

    // returned strobe gating
    logic        strobe_enable;
    logic        link_selected;

    // frame lifecycle: the link side drops its done flag the moment the
    // frame closes, so the local side must remember that the word left
    typedef enum logic [1:0] {
        ISCR_FRAME_IDLE,
        ISCR_FRAME_OPEN,
        ISCR_FRAME_DONE
    } iscr_frame_type;

    iscr_frame_type frame_state;
    iscr_frame_type next_frame_state;

    // the local clock itself is the jitter reference; a divided copy
    // goes across the isolator so the host can pace its sample start
    assign next_div_wrap = (div_count == HOST_CLK_HALF - 4'h1);

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            div_count         <= RST_DIV;
            host_side_clock_o <= 1'b0;
        end else if (next_div_wrap) begin
            div_count         <= RST_DIV;
            host_side_clock_o <= ~host_side_clock_o; // R6
        end else begin
            div_count         <= div_count + 4'h1;
        end
    end

    // the isolated sample start carries isolator jitter; sampling it on
    // the rising local edge puts the converter start back on the clean
    // clock. a second stage guards against metastability, at the cost of
    // one more fixed cycle of latency, which does not add jitter
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            start_retime <= 1'b0;
            start_q      <= 1'b0;
            start_qq     <= 1'b0;
        end else begin
            start_retime <= isolated_sample_start_i; // R8 R11
            start_q      <= start_retime;             // R8
            start_qq     <= start_q;
        end
    end

    // converter start level and a one-cycle rising-edge pulse
    assign retimed_sample_start_o = start_q;            // R8
    assign sample_start_edge_o    = start_q & ~start_qq; // R11

    // mode straps come from the host side, so they are synchronised first
    assign strap_zero = 3'h0;

    iscr_sync2 #(
        .W (3)
    ) u_strap_sync (
        .clk_i     (clk_i),
        .rst_b_i   (rst_b_i),
        .d_i       ({source_sync_sel_i, lane_sel_i}),
        .rst_val_i (strap_zero),
        .q_o       (strap_sync)
    );

    assign lane_sel_sync    = strap_sync[1:0];
    assign source_sync_sync = strap_sync[2];

    // strap decode: 00 one lane, 01 two lanes, 1x four lanes
    assign lanes_req = lane_sel_sync[1] ? ISCR_LANES_FOUR :
                       lane_sel_sync[0] ? ISCR_LANES_TWO  : ISCR_LANES_ONE; // R1
    assign mode_req  = source_sync_sync ? ISCR_MODE_SOURCE_SYNC
                                        : ISCR_MODE_CONV_CLOCKED;          // R2

    // frame signal seen on the local clock
    iscr_sync2 #(
        .W (1)
    ) u_frame_sync (
        .clk_i     (clk_i),
        .rst_b_i   (rst_b_i),
        .d_i       (frame_b_i),
        .rst_val_i (1'b1),
        .q_o       (frame_b_sync)
    );

    // word-complete flag from the link side; it rises with the last chunk and clears at frame end
    iscr_sync2 #(
        .W (1)
    ) u_done_sync (
        .clk_i     (clk_i),
        .rst_b_i   (rst_b_i),
        .d_i       (link_done),
        .rst_val_i (1'b0),
        .q_o       (done_sync)
    );

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            frame_b_prev <= 1'b1;
        end else begin
            frame_b_prev <= frame_b_sync;
        end
    end

    assign frame_open  = ~frame_b_sync;
    assign frame_start = frame_b_prev & ~frame_b_sync;
    assign frame_end   = ~frame_b_prev & frame_b_sync;

    // mode is frozen while a frame is open: the link domain reads these
    // registers directly, so they must not move under a running clock
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            lanes_held <= ISCR_LANES_ONE;
            mode_held  <= ISCR_MODE_CONV_CLOCKED;
        end else if (!frame_open) begin
            lanes_held <= lanes_req; // R1
            mode_held  <= mode_req;  // R2
        end
    end

    // a new result may only replace the hold word outside a frame; one
    // arriving during a frame is dropped and flagged rather than tearing
    // the word the host is shifting out
    assign take_result = conv_result_valid_i & ~frame_open;
    assign drop_result = conv_result_valid_i & frame_open;

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            hold_word <= RST_WORD;
        end else if (take_result) begin
            hold_word <= conv_result_i;
        end
    end

    // ready is set by a new word and cleared when a frame closes;
    // a result in the very cycle of the close wins over the clear
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            word_ready_o <= 1'b0;
        end else if (take_result) begin
            word_ready_o <= 1'b1;
        end else if (frame_end) begin
            word_ready_o <= 1'b0;
        end
    end

    // dropped result, sticky until the next frame opens
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            overrun_o <= 1'b0;
        end else if (drop_result) begin
            overrun_o <= 1'b1;
        end else if (frame_start) begin
            overrun_o <= 1'b0;
        end
    end

    // completion is latched while the frame is still open: done_sync is
    // already gone by the time the synced close arrives, since the link
    // side clears it together with the lanes
    always_comb begin
        next_frame_state = frame_state;
        unique case (frame_state)
            ISCR_FRAME_IDLE: begin
                if (frame_start) begin
                    next_frame_state = ISCR_FRAME_OPEN;
                end
            end
            ISCR_FRAME_OPEN: begin
                if (frame_end) begin
                    next_frame_state = ISCR_FRAME_IDLE;
                end else if (done_sync) begin
                    next_frame_state = ISCR_FRAME_DONE; // R10
                end
            end
            ISCR_FRAME_DONE: begin
                if (frame_end) begin
                    next_frame_state = ISCR_FRAME_IDLE;
                end
            end
            default: begin
                next_frame_state = ISCR_FRAME_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            frame_state <= ISCR_FRAME_IDLE;
        end else begin
            frame_state <= next_frame_state;
        end
    end

    // a frame that closes before the whole word left is reported
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            short_frame_o <= 1'b0;
        end else if (frame_end) begin
            short_frame_o <= (frame_state != ISCR_FRAME_DONE); // R10
        end else if (frame_start) begin
            short_frame_o <= 1'b0;
        end
    end

    // readout shifter on the host serial clock
    iscr_lane_shifter u_shifter (
        .link_sclk_i (link_sclk_i),
        .frame_b_i   (frame_b_i),
        .word_i      (hold_word),
        .lanes_i     (lanes_held),
        .lanes_o     (link_lanes),
        .done_o      (link_done)
    );

    assign serial_data_out_lanes_o = link_lanes; // R1 R10

    // in source-synchronous mode the host clock is looped back beside the
    // data so both see the same isolator delay; launch is on the rising
    // edge, so the host captures on the falling strobe edge. limitation:
    // the gate level comes from the other domain and is only frozen
    // during frames, so mode changes must happen while the link is idle
    assign strobe_enable           = (mode_held == ISCR_MODE_SOURCE_SYNC); // R2
    assign link_selected           = ~frame_b_i;
    assign returned_strobe_clock_o = strobe_enable & link_selected & link_sclk_i; // R3 R4

endmodule

// ---- rtl/iscr_sync2.sv ----
/*
 * Two flip-flop level synchroniser.
 * Assumes a quasi-static or slowly changing level on d_i; a multi-bit
 * d_i must only change one bit at a time or be held until consumed.
 */
module iscr_sync2 #(
    parameter int W = 1
) (
    input  wire logic         clk_i,
    input  wire logic         rst_b_i,
    input  wire logic [W-1:0] d_i,
    input  wire logic [W-1:0] rst_val_i,
    output logic      [W-1:0] q_o
);
    import iscr_pkg::*;

    logic [W-1:0] meta;

    // first stage is read by the second stage only
    // both stages reset to the idle level of the source, so no false
    // edge shows up in the first cycles after reset
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            meta <= rst_val_i;
            q_o  <= rst_val_i;
        end else begin
            meta <= d_i;
            q_o  <= meta;
        end
    end

endmodule

// ---- verification/iscr_host_model.sv ----
/*
 * Behavioural host across the isolator: serial master and start source.
 * Assumes host_clk_i is the clock sent over by the converter side.
 */
module iscr_host_model (
    input  wire logic        host_clk_i,
    input  wire logic [3:0]  lanes_i,
    input  wire logic        strobe_i,
    output logic             frame_b_o,
    output logic             sclk_o,
    output logic             start_o,
    output logic             got_o,
    output logic [23:0]      acc_o,
    output logic [4:0]       edges_o
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        frame_b_o = 1'b0;
        sclk_o = 1'b0;
        start_o = 1'b0;
        got_o = 1'b0;
        acc_o = 24'h00_0000;
        edges_o = 5'h00;
        // link logic only clears on a rising frame select
        #1 frame_b_o = 1'b1;
    end
    // returned strobe edges seen in a frame
    always @(negedge strobe_i) edges_o <= edges_o + 5'h01;
    // clock runs only inside the frame, 30 ns period
    task automatic read(input int n, input int w);
        frame_b_o = 1'b0;
        acc_o = 24'h00_0000;
        edges_o = 5'h00;
        #21; // lead time, serial edges kept off the local clock edges
        repeat (n) begin
            sclk_o = 1'b1;
            #15;
            acc_o = 24'((acc_o << w) | (lanes_i & ((1 << w) - 1)));
            sclk_o = 1'b0;
            #15;
        end
        frame_b_o = 1'b1;
        got_o = 1'b1;
        #20;
        got_o = 1'b0;
    endtask
    // start derived from received clock, isolator delay added
    task automatic pulse();
        @(posedge host_clk_i);
        #3 start_o = 1'b1;
        repeat (3) @(posedge host_clk_i);
        #3 start_o = 1'b0;
    endtask
endmodule

// ---- verification/iscr_retimer_asserts.sv ----
/*
 * Port-level timing checks for the retimer.
 * Assumes a bind into iscr_retimer; all checks sample on clk_i.
 */
module iscr_retimer_asserts (
    input wire logic        clk_i,
    input wire logic        rst_b_i,
    input wire logic        isolated_sample_start_i,
    input wire logic        host_side_clock_o,
    input wire logic        retimed_sample_start_o,
    input wire logic        sample_start_edge_o,
    input wire logic [19:0] conv_result_i,
    input wire logic        conv_result_valid_i,
    input wire logic [1:0]  lane_sel_i,
    input wire logic        source_sync_sel_i,
    input wire logic        link_sclk_i,
    input wire logic        frame_b_i,
    input wire logic [3:0]  serial_data_out_lanes_o,
    input wire logic        returned_strobe_clock_o,
    input wire logic        word_ready_o,
    input wire logic        overrun_o,
    input wire logic        short_frame_o
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    // frame states long enough for the two-stage sync to settle
    sequence s_closed; frame_b_i [*4]; endsequence
    sequence s_open; (!frame_b_i) [*4]; endsequence
    sequence s_close_done; $rose(frame_b_i) ##1 (frame_b_i && !conv_result_valid_i) [*5]; endsequence
    a_start_delay: assert property (retimed_sample_start_o == $past(isolated_sample_start_i, 2))
        else $error("retimed start not two cycles behind input");
    a_edge_pulse: assert property (sample_start_edge_o ==
        (retimed_sample_start_o && !$past(retimed_sample_start_o))) else $error("bad start edge");
    a_host_clock: assert property ($past(rst_b_i, 3) && $past(rst_b_i, 2) && $past(rst_b_i)
        |-> host_side_clock_o != $past(host_side_clock_o)) else $error("host clock stuck");
    a_ready_set: assert property (s_closed ##0 conv_result_valid_i |=> word_ready_o)
        else $error("result not held");
    a_ready_clear: assert property (s_close_done |=> !word_ready_o)
        else $error("word ready after frame close");
    a_overrun_set: assert property (s_open ##0 conv_result_valid_i |=> overrun_o)
        else $error("overrun not flagged");
    a_lanes_idle: assert property (frame_b_i |-> serial_data_out_lanes_o == 4'h0)
        else $error("lanes active outside frame");
    a_strobe_idle: assert property (frame_b_i |-> !returned_strobe_clock_o)
        else $error("strobe outside frame");
    a_strobe_mode: assert property ((!source_sync_sel_i) [*8] |-> !returned_strobe_clock_o)
        else $error("strobe in converter-clocked mode");
    a_one_lane: assert property ((lane_sel_i == 2'h0) [*8] |-> serial_data_out_lanes_o[3:1] == 3'h0)
        else $error("unused lanes driven");
    a_two_lane: assert property ((lane_sel_i == 2'h1) [*8] |-> serial_data_out_lanes_o[3:2] == 2'h0)
        else $error("unused lanes driven");
endmodule

bind iscr_retimer iscr_retimer_asserts u_chk (.clk_i, .rst_b_i, .isolated_sample_start_i,
    .host_side_clock_o, .retimed_sample_start_o, .sample_start_edge_o, .conv_result_i,
    .conv_result_valid_i, .lane_sel_i, .source_sync_sel_i, .link_sclk_i, .frame_b_i,
    .serial_data_out_lanes_o, .returned_strobe_clock_o, .word_ready_o, .overrun_o, .short_frame_o);

// ---- verification/tb_iscr_retimer.sv ----
/*
 * Self-checking bench for the retimer with a host model on the link.
 * Assumes the checker is bound in and a 200 MHz local clock.
 */
module tb_iscr_retimer;
    import iscr_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk_i = 1'b0, rst_b_i = 1'b0, conv_result_valid_i = 1'b0;
    logic        source_sync_sel_i = 1'b0, isolated_sample_start_i, link_sclk_i, frame_b_i;
    logic        host_side_clock_o, retimed_sample_start_o, sample_start_edge_o, got;
    logic        returned_strobe_clock_o, word_ready_o, overrun_o, short_frame_o;
    logic [1:0]  lane_sel_i = 2'h0;
    logic [3:0]  serial_data_out_lanes_o;
    logic [4:0]  edges;
    logic [19:0] conv_result_i = 20'h0_0000, d, e;
    logic [23:0] acc;
    logic [28:0] expd, q[$];
    logic [31:0] seed = 32'h0000_cd50;
    int          err_count = 0, checks = 0, pulses = 0;
    always #2.5 clk_i = ~clk_i;
    iscr_retimer u_dut (.clk_i, .rst_b_i, .isolated_sample_start_i, .host_side_clock_o,
        .retimed_sample_start_o, .sample_start_edge_o, .conv_result_i, .conv_result_valid_i,
        .lane_sel_i, .source_sync_sel_i, .link_sclk_i, .frame_b_i, .serial_data_out_lanes_o,
        .returned_strobe_clock_o, .word_ready_o, .overrun_o, .short_frame_o);
    iscr_host_model u_host (.host_clk_i(host_side_clock_o), .lanes_i(serial_data_out_lanes_o),
        .strobe_i(returned_strobe_clock_o), .frame_b_o(frame_b_i), .sclk_o(link_sclk_i),
        .start_o(isolated_sample_start_i), .got_o(got), .acc_o(acc), .edges_o(edges));
    function automatic logic [19:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[19:0];
    endfunction
    function automatic int wid(input logic [1:0] s);
        return (s == 2'h0) ? WIDTH_ONE_LANE : (s == 2'h1) ? WIDTH_TWO_LANE : WIDTH_FOUR_LANE;
    endfunction
    function automatic int nclk(input logic [1:0] s);
        return (s == 2'h0) ? CLOCKS_ONE_LANE : (s == 2'h1) ? CLOCKS_TWO_LANE : CLOCKS_FOUR_LANE;
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic test_done();
        if (err_count == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // one-cycle result strobe, ready expected one cycle on
    task automatic load(input logic [19:0] v);
        @(negedge clk_i);
        conv_result_i = v;
        conv_result_valid_i = 1'b1;
        @(negedge clk_i);
        conv_result_valid_i = 0;
        check(word_ready_o, 1);
    endtask
    // note expected stream prefix and strobe count, then read n clocks
    task automatic rd(input int n, input logic [19:0] v);
        logic [43:0] s;
        s = {v, 24'h00_0000} >> (44 - n * wid(lane_sel_i));
        q.push_back({5'(source_sync_sel_i ? n : 0), s[23:0]});
        u_host.read(n, wid(lane_sel_i));
        repeat (6) @(negedge clk_i);
    endtask
    // oldest note against each captured frame
    always @(posedge got) begin
        expd = q.pop_front();
        check({3'h0, edges, acc}, {3'h0, expd});
    end
    always @(posedge clk_i) if (sample_start_edge_o === 1'b1) pulses++;
    initial begin
        repeat (10) @(negedge clk_i);
        rst_b_i = 1'b1;
        check({word_ready_o, overrun_o, short_frame_o, serial_data_out_lanes_o}, 0);
        repeat (3) u_host.pulse();
        repeat (10) @(negedge clk_i);
        check(pulses, 3);
        // back-to-back results, later one must win
        d = xs();
        e = xs();
        @(negedge clk_i);
        conv_result_i = d;
        conv_result_valid_i = 1'b1;
        @(negedge clk_i);
        conv_result_i = e;
        @(negedge clk_i);
        conv_result_valid_i = 1'b0;
        rd(nclk(2'h0) + 1, e);
        // result during open frame is dropped, old word still sent
        d = xs();
        e = xs();
        load(d);
        fork
            rd(nclk(2'h0) + 1, d);
            begin
                repeat (10) @(negedge clk_i);
                load(e);
            end
        join
        check({overrun_o, word_ready_o}, 2'h2);
        // early close leaves the word incomplete
        load(e);
        rd(3, e);
        check({short_frame_o, overrun_o}, 2'h2);
        // every lane width in both readout modes; source-sync strap set on the last four passes
        for (int m = 0; m < 8; m++) begin
            @(negedge clk_i);
            lane_sel_i = 2'(m);
            source_sync_sel_i = m[2];
            repeat (10) @(negedge clk_i);
            d = xs();
            load(d);
            rd(nclk(lane_sel_i) + 1, d);
            check({short_frame_o, word_ready_o}, 2'h0);
        end
        check(q.size(), 0);
        test_done();
    end
endmodule
